// ==== rtl/sram_pkg.sv ====
// Shared constants, command types and burst helper for the synchronous RAM block
package sram_pkg;

    // ------------------------------------------------------------
    // Geometry
    // ------------------------------------------------------------
    localparam int ADDR_W = 6;
    localparam int DEPTH  = 64;
    localparam int LANES  = 4;
    localparam int LANE_W = 9;
    localparam int DATA_W = 36;

    // ------------------------------------------------------------
    // Reset values and encodings
    // ------------------------------------------------------------
    localparam logic [LANES-1:0]  MASK_NONE      = 4'hf;
    localparam logic [1:0]        BURST_STEP_RST = 2'h0;
    localparam logic [1:0]        BURST_BASE_RST = 2'h0;
    localparam logic [DATA_W-1:0] DATA_RST       = 36'h0;
    localparam logic [ADDR_W-1:0] ADDR_RST       = 6'h00;
    localparam int                BURST_LSB      = 0;
    localparam int                BURST_MSB      = 1;

    // Operation held by a pipeline slot; also the last loaded burst type
    typedef enum logic [1:0] {
        OP_IDLE  = 2'b00,
        OP_READ  = 2'b01,
        OP_WRITE = 2'b10
    } op_t;

    typedef struct packed {
        op_t              op;
        logic [ADDR_W-1:0] addr;
        logic [LANES-1:0]  mask_n;
    } cmd_t;

    localparam cmd_t CMD_RST = '{op: OP_IDLE, addr: ADDR_RST, mask_n: MASK_NONE};

    // Low address bits of a burst: linear adds the step, interleaved xors it
    function automatic logic [1:0] burst_low(input logic [1:0] base,
                                             input logic [1:0] step,
                                             input logic       interleave);
        burst_low = interleave ? (base ^ step) : 2'(base + step);
    endfunction

    // Per-lane write merge; a high mask bit keeps the stored lane
    function automatic logic [DATA_W-1:0] merge_lanes(input logic [DATA_W-1:0] old_w,
                                                      input logic [DATA_W-1:0] new_w,
                                                      input logic [LANES-1:0]  mask_n);
        logic [DATA_W-1:0] res;
        res = old_w;
        for (int i = 0; i < LANES; i++) begin
            if (!mask_n[i]) begin
                res[i*LANE_W +: LANE_W] = new_w[i*LANE_W +: LANE_W];
            end
        end
        merge_lanes = res;
    endfunction

endpackage

// ==== rtl/burst_counter.sv ====
// Two-bit burst address generator with load and step
`timescale 1ns/1ps
`default_nettype none

module burst_counter (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       nrst,
    // Control
    input  wire logic       load,
    input  wire logic       step,
    input  wire logic       interleave,
    input  wire logic [1:0] preset,
    // Generated low address bits for this edge
    output logic      [1:0] low_now
);
    import sram_pkg::*;

    logic [1:0] base_r;
    logic [1:0] step_r;
    logic [1:0] step_nxt;

    assign step_nxt = 2'(step_r + 2'h1);
    // Load uses the preset directly; a step uses the advanced count
    assign low_now  = load ? preset : burst_low(base_r, step_nxt, interleave);

    always_ff @(posedge clk) begin
        if (!nrst) begin
            base_r <= BURST_BASE_RST;
        end else if (load) begin
            base_r <= preset;
        end
    end

    // Two-bit count wraps after four addresses
    always_ff @(posedge clk) begin
        if (!nrst) begin
            step_r <= BURST_STEP_RST;
        end else if (load) begin
            step_r <= BURST_STEP_RST;
        end else if (step) begin
            step_r <= step_nxt;
        end
    end

endmodule

`default_nettype wire

// ==== rtl/sync_sram.sv ====
// Synchronous late-write RAM: command capture, stall, select, masking, latency modes
`timescale 1ns/1ps
`default_nettype none

module sync_sram (
    // Clock and reset
    input  wire logic                         clk,
    input  wire logic                         nrst,
    // Command and address
    input  wire logic [sram_pkg::ADDR_W-1:0]  addr,
    input  wire logic                         clk_en_n,
    input  wire logic                         load_or_step,
    input  wire logic                         write_n,
    input  wire logic                         select_low_1,
    input  wire logic                         select_high,
    input  wire logic                         select_low_3,
    // Byte lane write masks, active low
    input  wire logic                         lane0_mask_n,
    input  wire logic                         lane1_mask_n,
    input  wire logic                         lane2_mask_n,
    input  wire logic                         lane3_mask_n,
    // Static and unclocked controls
    input  wire logic                         output_en_n,
    input  wire logic                         latency_mode_sel,
    input  wire logic                         order_sel_n,
    input  wire logic                         sleep_req,
    // Shared data bus, split into its three signals
    input  wire logic [sram_pkg::DATA_W-1:0]  dq_in,
    output logic      [sram_pkg::DATA_W-1:0]  dq_out,
    output logic                              dq_oe_n,
    // Status
    output logic                              asleep
);
    import sram_pkg::*;

    // ------------------------------------------------------------
    // Storage and pipeline state
    // ------------------------------------------------------------
    logic [DATA_W-1:0] mem_r [DEPTH];
    cmd_t              slot1_r;
    cmd_t              slot2_r;
    op_t               burst_op_r;
    logic [ADDR_W-1:0] burst_hi_r;
    logic [DATA_W-1:0] dout_r;
    logic              drive_r;
    logic              asleep_r;
    logic              sleep_s1_r;
    logic              sleep_s2_r;
    logic              order_s1_r;
    logic              order_s2_r;
    logic              flow_r;
    logic              mode_s1_r;
    logic              mode_s2_r;

    // ------------------------------------------------------------
    // Command decode
    // ------------------------------------------------------------
    logic              edge_live;
    logic              selected;
    logic              do_load;
    logic              do_step;
    logic [1:0]        low_now;
    logic [LANES-1:0]  mask_now;
    cmd_t              cmd_now;
    cmd_t              out_slot;
    cmd_t              wr_slot;

    // A stalled edge freezes the slots, burst, memory and output state; a sleeping edge freezes them and clears the driver
    assign edge_live = !clk_en_n && !asleep_r;
    assign selected  = !select_low_1 && select_high && !select_low_3;
    assign do_load   = edge_live && !load_or_step;
    assign do_step   = edge_live && load_or_step;
    assign mask_now  = {lane3_mask_n, lane2_mask_n, lane1_mask_n, lane0_mask_n};

    burst_counter u_burst (
        .clk        (clk),
        .nrst       (nrst),
        .load       (do_load),
        .step       (do_step),
        .interleave (order_s2_r),
        .preset     (addr[BURST_MSB:BURST_LSB]),
        .low_now    (low_now)
    );

    always_comb begin
        cmd_now = CMD_RST;
        if (!load_or_step) begin
            if (selected && write_n) begin
                cmd_now = '{op: OP_READ, addr: addr, mask_n: MASK_NONE};
            end else if (selected) begin
                cmd_now = '{op: OP_WRITE, addr: addr, mask_n: mask_now};
            end
        end else begin
            // Continue cycle repeats the loaded type at the generated address
            cmd_now.op     = burst_op_r;
            cmd_now.addr   = {burst_hi_r[ADDR_W-1:2], low_now};
            cmd_now.mask_n = (burst_op_r == OP_WRITE) ? mask_now : MASK_NONE;
        end
    end

    // Flow-through takes read data and write data one edge earlier
    assign out_slot = flow_r ? cmd_now : slot1_r;
    assign wr_slot  = flow_r ? slot1_r : slot2_r;

    // ------------------------------------------------------------
    // Static mode and asynchronous pin capture
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!nrst) begin
            order_s1_r <= 1'b0;
            order_s2_r <= 1'b0;
        end else begin
            order_s1_r <= order_sel_n;
            order_s2_r <= order_s1_r;
        end
    end

    // Mode pin is static but still comes from outside, so it is synchronised first
    always_ff @(posedge clk) begin
        if (!nrst) begin
            mode_s1_r <= 1'b1;
            mode_s2_r <= 1'b1;
        end else begin
            mode_s1_r <= latency_mode_sel;
            mode_s2_r <= mode_s1_r;
        end
    end

    // Mode is taken whenever both slots are idle, even on an edge that loads a command into slot1_r, which then runs in the new mode
    always_ff @(posedge clk) begin
        if (!nrst) begin
            flow_r <= 1'b0;
        end else if (slot1_r.op == OP_IDLE && slot2_r.op == OP_IDLE) begin
            flow_r <= !mode_s2_r;
        end
    end

    // Sleep takes effect three edges after the request, and leaves likewise
    always_ff @(posedge clk) begin
        if (!nrst) begin
            sleep_s1_r <= 1'b0;
            sleep_s2_r <= 1'b0;
            asleep_r   <= 1'b0;
        end else begin
            sleep_s1_r <= sleep_req;
            sleep_s2_r <= sleep_s1_r;
            asleep_r   <= sleep_s2_r;
        end
    end

    // ------------------------------------------------------------
    // Burst tracking
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!nrst) begin
            burst_op_r <= OP_IDLE;
            burst_hi_r <= ADDR_RST;
        end else if (do_load) begin
            burst_op_r <= cmd_now.op;
            burst_hi_r <= addr;
        end
    end

    // ------------------------------------------------------------
    // Command pipeline
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!nrst) begin
            slot1_r <= CMD_RST;
            slot2_r <= CMD_RST;
        end else if (edge_live) begin
            slot1_r <= cmd_now;
            slot2_r <= slot1_r;
        end
    end

    // ------------------------------------------------------------
    // Late write into the core
    // ------------------------------------------------------------
    // A write with every mask high merges nothing and leaves the word as is
    always_ff @(posedge clk) begin
        if (edge_live && wr_slot.op == OP_WRITE && wr_slot.mask_n != MASK_NONE) begin
            mem_r[wr_slot.addr] <= merge_lanes(mem_r[wr_slot.addr], dq_in, wr_slot.mask_n);
        end
    end

    // ------------------------------------------------------------
    // Read output register and driver state
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!nrst) begin
            dout_r <= DATA_RST;
        end else if (edge_live && out_slot.op == OP_READ) begin
            dout_r <= mem_r[out_slot.addr];
        end
    end

    // Driver state is held through a stall, so a read keeps driving and
    // a write keeps the bus released; write slots always release it
    always_ff @(posedge clk) begin
        if (!nrst) begin
            drive_r <= 1'b0;
        end else if (asleep_r) begin
            drive_r <= 1'b0;
        end else if (edge_live) begin
            drive_r <= (out_slot.op == OP_READ);
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            asleep <= 1'b0;
        end else begin
            asleep <= sleep_s2_r;
        end
    end

    // ------------------------------------------------------------
    // Pins
    // ------------------------------------------------------------
    assign dq_out = dout_r;
    // Output enable bypasses the clock so the bus frees at once
    assign dq_oe_n = !drive_r || output_en_n;

endmodule

`default_nettype wire

// ==== bench/sync_sram_checker.sv ====
// Port-level assertion checker for the synchronous RAM
`timescale 1ns/1ps
`default_nettype none

module sync_sram_checker (
    // Clock and reset
    input wire logic                        clk,
    input wire logic                        nrst,
    // Watched ports
    input wire logic                        clk_en_n,
    input wire logic                        load_or_step,
    input wire logic                        write_n,
    input wire logic                        select_low_1,
    input wire logic                        select_high,
    input wire logic                        select_low_3,
    input wire logic                        output_en_n,
    input wire logic                        latency_mode_sel,
    input wire logic                        asleep,
    input wire logic [sram_pkg::DATA_W-1:0] dq_out,
    input wire logic                        dq_oe_n
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    logic live;
    logic sel;
    logic ld;
    assign live = !clk_en_n && !asleep;
    assign sel  = !select_low_1 && select_high && !select_low_3;
    assign ld   = live && !load_or_step;

    chk_pipe_read_out: assert property (ld && sel && write_n && latency_mode_sel ##1 live
        |=> dq_oe_n == output_en_n)
        else $error("pipeline read not driven");
    chk_ft_read_out: assert property (ld && sel && write_n && !latency_mode_sel |=> dq_oe_n == output_en_n)
        else $error("flow-through read not driven");
    chk_pipe_write_off: assert property (ld && sel && !write_n && latency_mode_sel ##1 live |=> dq_oe_n)
        else $error("pipeline write slot driven");
    chk_ft_write_off: assert property (ld && sel && !write_n && !latency_mode_sel |=> dq_oe_n)
        else $error("flow-through write slot driven");
    chk_desel_low_one: assert property (ld && select_low_1 && latency_mode_sel ##1 live |=> dq_oe_n)
        else $error("deselected slot driven");
    chk_desel_high_sel: assert property (ld && !select_high && !latency_mode_sel |=> dq_oe_n)
        else $error("select high negated yet driven");
    chk_stall_data: assert property (clk_en_n |=> $stable(dq_out))
        else $error("data moved on ignored edge");
    chk_stall_drive: assert property (clk_en_n ##1 $stable(output_en_n) |-> $stable(dq_oe_n))
        else $error("drive changed on ignored edge");
    chk_oe_force: assert property (output_en_n |-> dq_oe_n)
        else $error("output enable off yet driven");
endmodule

bind sync_sram sync_sram_checker u_chk (.clk, .nrst, .clk_en_n, .load_or_step, .write_n, .select_low_1,
    .select_high, .select_low_3, .output_en_n, .latency_mode_sel, .asleep, .dq_out, .dq_oe_n);

`default_nettype wire

// ==== bench/sram_host.sv ====
// Controller model: issues commands and hands late write data to the RAM
`timescale 1ns/1ps
`default_nettype none

module sram_host (
    // Clock and mode
    input  wire logic                        clk,
    input  wire logic                        pipe,
    // Command side
    output logic      [sram_pkg::ADDR_W-1:0] addr,
    output logic                             clk_en_n,
    output logic                             load_or_step,
    output logic                             write_n,
    output logic      [2:0]                  sel,
    output logic      [sram_pkg::LANES-1:0]  mask_n,
    // Write data
    output logic      [sram_pkg::DATA_W-1:0] dq_in
);
    import sram_pkg::*;
    logic [DATA_W-1:0] wd;
    logic [DATA_W-1:0] d1;
    logic [DATA_W-1:0] d2;

    initial begin
        addr = '0;
        clk_en_n = 1'b0;
        load_or_step = 1'b0;
        write_n = 1'b1;
        sel = 3'h7;
        mask_n = MASK_NONE;
        wd = '0;
    end

    // Data only moves on live edges, so stalls stretch the late write
    always_ff @(posedge clk) begin
        if (!clk_en_n) begin
            d1 <= wd;
            d2 <= d1;
        end
    end
    assign dq_in = pipe ? d2 : d1;

    // Kind: 0 read, 1 write, 2 burst step, 3 stall; read and stall slots toggle the bus
    task automatic cycle(input logic [1:0] k, input logic [ADDR_W-1:0] a, input logic [2:0] s,
                         input logic [LANES-1:0] m, input logic [DATA_W-1:0] d);
        @(posedge clk);
        #1;
        clk_en_n = (k == 2'h3);
        load_or_step = (k == 2'h2);
        write_n = (k != 2'h1);
        addr = a;
        sel = s;
        mask_n = m;
        wd = (k == 2'h1 || k == 2'h2) ? d : ~wd;
    endtask
endmodule

`default_nettype wire

// ==== bench/sync_sram_tb.sv ====
// Self-checking bench for the synchronous RAM
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin num_errors++; \
    $display("CHECK FAILED %s expected %h seen %h", nm, e, g); end end

module sync_sram_tb;
    import sram_pkg::*;
    localparam logic [2:0] SEL = 3'h2;
    logic              clk = 1'b0;
    logic              nrst = 1'b0;
    logic              output_en_n = 1'b0;
    logic              pipe = 1'b1;
    logic              order_sel_n = 1'b0;
    logic              sleep_req = 1'b0;
    logic [ADDR_W-1:0] addr;
    logic              clk_en_n, load_or_step, write_n, dq_oe_n, asleep;
    logic [2:0]        sel;
    logic [LANES-1:0]  mask_n;
    logic [DATA_W-1:0] dq_in, dq_out;
    logic [DATA_W-1:0] mem_m [DEPTH];
    logic [DATA_W-1:0] ev [256];
    logic [1:0]        ek [256];
    logic [1:0]        lt, bb, bk;
    logic [3:0]        hi;
    int                edges, num_errors, n_tests;
    bit                prev_live;

    always #20 clk = ~clk;

    sram_host u_host (.clk, .pipe, .addr, .clk_en_n, .load_or_step, .write_n, .sel, .mask_n, .dq_in);
    sync_sram u_dut (.clk, .nrst, .addr, .clk_en_n, .load_or_step, .write_n,
        .select_low_1(sel[2]), .select_high(sel[1]), .select_low_3(sel[0]), .lane0_mask_n(mask_n[0]),
        .lane1_mask_n(mask_n[1]), .lane2_mask_n(mask_n[2]), .lane3_mask_n(mask_n[3]), .output_en_n,
        .latency_mode_sel(pipe), .order_sel_n, .sleep_req, .dq_in, .dq_out, .dq_oe_n, .asleep);

    // ------------------------------------------------------------
    // One bus cycle plus scoreboard, keyed by live edge count
    // ------------------------------------------------------------
    task automatic op(input logic [1:0] k, input logic [ADDR_W-1:0] a, input logic [2:0] s,
                      input logic [LANES-1:0] m, input logic [DATA_W-1:0] d);
        logic [ADDR_W-1:0] ba;
        logic [DATA_W-1:0] dv;
        int                due;
        // Data flips with the mode so flow-through writes cannot hide behind older contents
        dv = d ^ {DATA_W{pipe}};
        u_host.cycle(k, a, s, m, dv);
        if (prev_live) edges++;
        prev_live = (k != 2'h3);
        due = edges + (pipe ? 2 : 1);
        if (k == 2'h2) begin
            bk++;
        end else if (k != 2'h3) begin
            lt = (s != SEL) ? 2'h2 : (k == 2'h0) ? 2'h1 : 2'h3;
            {hi, bb} = a;
            bk = 2'h0;
        end
        ba = {hi, order_sel_n ? (bb ^ bk) : 2'(bb + bk)};
        if (k != 2'h3) begin
            ek[due] = (lt == 2'h1) ? 2'h1 : 2'h2;
            ev[due] = mem_m[ba];
            for (int i = 0; i < LANES; i++)
                if (lt == 2'h3 && !m[i]) mem_m[ba][i*LANE_W +: LANE_W] = dv[i*LANE_W +: LANE_W];
        end
        if (ek[edges] == 2'h1) begin
            `CHK("read data", ev[edges], dq_out)
            `CHK("read drive", 1'b0, dq_oe_n)
        end else if (ek[edges] == 2'h2) begin
            `CHK("drive off", 1'b1, dq_oe_n)
        end
    endtask

    task automatic idle(input int n);
        repeat (n) op(2'h0, '0, 3'h7, MASK_NONE, '0);
    endtask

    task automatic t_rw();
        op(2'h1, 6'h04, SEL, 4'h0, 36'h123456789);
        op(2'h1, 6'h05, SEL, 4'h0, 36'hfedcba987);
        op(2'h1, 6'h06, SEL, 4'h0, 36'h0f0f0f0f0);
        op(2'h0, 6'h04, SEL, 4'hf, '0);
        op(2'h1, 6'h05, SEL, 4'h5, 36'h555555555);
        op(2'h0, 6'h06, SEL, 4'hf, '0);
        op(2'h1, 6'h06, SEL, 4'hf, 36'hbadbadbad);
        op(2'h0, 6'h05, SEL, 4'hf, '0);
        op(2'h0, 6'h06, SEL, 4'hf, '0);
        idle(3);
        $display("read write test done");
    endtask

    task automatic t_sel();
        for (int i = 0; i < 3; i++) op(2'h0, 6'h04, SEL ^ (3'h1 << i), 4'hf, '0);
        idle(3);
        $display("select test done");
    endtask

    task automatic t_burst(input logic ord);
        order_sel_n = ord;
        idle(3);
        op(2'h1, 6'h0a, SEL, 4'h0, 36'h0aaaaaaa0);
        for (int i = 1; i < 4; i++) op(2'h2, 6'h3f, SEL, 4'h0, {4{9'(i * 37)}});
        idle(2);
        op(2'h0, 6'h09, SEL, 4'hf, '0);
        for (int i = 0; i < 4; i++) op(2'h2, 6'h00, SEL, 4'hf, '0);
        idle(3);
        $display("burst test done");
    endtask

    task automatic t_stall();
        op(2'h0, 6'h04, SEL, 4'hf, '0);
        op(2'h0, 6'h06, SEL, 4'hf, '0);
        op(2'h3, 6'h05, SEL, 4'hf, '0);
        op(2'h3, 6'h05, SEL, 4'hf, '0);
        #5;
        output_en_n = 1'b1;
        #1;
        `CHK("oe override", 1'b1, dq_oe_n)
        output_en_n = 1'b0;
        op(2'h1, 6'h07, SEL, 4'h0, 36'h7e7e7e7e7);
        idle(1);
        op(2'h3, 6'h00, SEL, 4'hf, '0);
        op(2'h3, 6'h00, SEL, 4'hf, '0);
        idle(3);
        op(2'h0, 6'h07, SEL, 4'hf, '0);
        idle(3);
        $display("stall test done");
    endtask

    // Sleep freezes a pending read and frees the bus; the read resumes on wake
    task automatic t_sleep();
        op(2'h0, 6'h04, SEL, 4'hf, '0);
        sleep_req = 1'b1;
        repeat (2) @(posedge clk);
        #1;
        `CHK("asleep early", 1'b0, asleep)
        output_en_n = 1'b1;
        @(posedge clk);
        #1;
        output_en_n = 1'b0;
        `CHK("asleep set", 1'b1, asleep)
        @(posedge clk);
        #1;
        `CHK("sleep drive", 1'b1, dq_oe_n)
        sleep_req = 1'b0;
        repeat (3) @(posedge clk);
        #1;
        `CHK("asleep clear", 1'b0, asleep)
        @(posedge clk);
        #1;
        `CHK("wake drive", 1'b0, dq_oe_n)
        `CHK("wake data", mem_m[6'h04], dq_out)
        $display("sleep test done");
    endtask

    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // Whole run is about 115 bus cycles
    initial begin
        repeat (2000) @(posedge clk);
        num_errors++;
        $display("watchdog expired");
        stop_test();
    end

    initial begin
        foreach (ek[i]) ek[i] = 2'h0;
        repeat (8) @(posedge clk);
        #1;
        nrst = 1'b1;
        for (int md = 1; md >= 0; md--) begin
            pipe = md[0];
            idle(4);
            t_rw();
            t_sel();
            t_burst(!md[0]);
        end
        pipe = 1'b1;
        idle(4);
        t_stall();
        t_sleep();
        stop_test();
    end
endmodule

`default_nettype wire
